// >>> core/epe_pkg.sv
package epe_pkg;

   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_DIV_HIGH = 8'hEE;
   localparam logic [7:0] IDX_DIV_LOW = 8'hEF;
   localparam logic [7:0] IDX_MODULE_CFG = 8'hF0;
   localparam logic [7:0] IDX_BLOCK_PROT = 8'hF1;
   localparam logic [7:0] IDX_PROG_CTRL = 8'hF3;

   // module_config_register fields
   localparam int CFG_DBG_LOCKOUT_DIS = 7;
   localparam int CFG_SHADOW_DIS = 6;
   localparam int CFG_TEST = 5;
   localparam int CFG_MAIN_OPEN = 4;
   localparam int CFG_FIXED_ONE = 3;
   localparam int CFG_WAIT_STOP = 2;
   localparam int CFG_PROT_LOCK = 1;
   localparam int CFG_DUMMY = 0;
   localparam logic [7:0] CFG_RESET = 8'h0C;

   // block_protect_register fields
   localparam int PROT_SHADOW = 7;
   localparam logic [7:0] PROT_MASK = 8'h9F;
   localparam logic [7:0] PROT_RESET = 8'h9F;

   // program_control_register fields
   localparam int PC_BULK_PROT = 7;
   localparam int PC_AUTO = 5;
   localparam int PC_BYTE = 4;
   localparam int PC_ROW = 3;
   localparam int PC_ERASE = 2;
   localparam int PC_LATCH = 1;
   localparam int PC_ENABLE = 0;
   localparam logic [7:0] PC_RESET = 8'h80;

   // shadow word layout and location
   localparam int SHW_DIV_HIGH_LSB = 8;
   localparam logic [11:0] SHADOW_ADDR = 12'hFC0;
   localparam logic [11:0] REGION4_LO = 12'hC00;
   localparam logic [11:0] REGION3_LO = 12'hE00;
   localparam logic [11:0] REGION2_LO = 12'hF00;
   localparam logic [11:0] REGION1_LO = 12'hF80;
   localparam logic [11:0] REGION0_LO = 12'hFC0;

   // program/erase duration in self-time ticks
   localparam int PE_TIME_US = 10000;
   localparam int TICK_US = 35;
   localparam int PE_TICKS = (PE_TIME_US + TICK_US - 1) / TICK_US;

   typedef enum logic [1:0] {
      EPE_SZ_BYTE,
      EPE_SZ_WORD,
      EPE_SZ_ROW,
      EPE_SZ_BULK
   } epe_size_t;

endpackage : epe_pkg

// >>> core/epe_self_timer.sv
`timescale 1ns/1ns
`default_nettype none

module epe_self_timer #(
   parameter int TICKS = epe_pkg::PE_TICKS
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic run,
   input wire logic [9:0] divider,
   output logic done
);

   typedef struct packed {
      logic [9:0] pre;
      logic [15:0] ticks;
      logic done;
   } epe_tmr_t;

   epe_tmr_t st_r;
   epe_tmr_t st_nxt;

   always_comb begin
      st_nxt = st_r;
      st_nxt.done = 1'b0;
      if (!run) begin
         st_nxt.pre = '0;
         st_nxt.ticks = '0;
      end else if (st_r.pre >= divider - 10'h001) begin
         // one self-time tick every divider clocks
         st_nxt.pre = '0;
         if (st_r.ticks >= 16'(TICKS - 1)) begin
            st_nxt.ticks = '0;
            st_nxt.done = 1'b1;
         end else begin
            st_nxt.ticks = st_r.ticks + 16'h0001;
         end
      end else begin
         st_nxt.pre = st_r.pre + 10'h001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '0;
      end else if (clk_en) begin
         st_r <= st_nxt;
      end
   end

   assign done = st_r.done;

endmodule : epe_self_timer

`default_nettype wire

// >>> core/epe_ctrl.sv
//
// Overview of operation
// - protect register writable only when idle, unlocked
// - shadow protect blocks shadow word modify
// - five region bits block program and byte erase in their address ranges
// - bulk protect blocks bulk/row erase, resets one
// - auto mode clears enable when cycle ends
// - byte and row bits choose erase size
// - program mode ignores byte and row bits
// - byte erase hits latched byte or word
// - latch bit frozen when enabled or divider zero
// - enable settable only after latch already set
// - control bits frozen while enable is set
// - protected address never starts, enable stays
// - array writes ignored, latches frozen while enabled
// - repeated writes allowed without clearing latch
// - shadow word loads config and divider
// - normal mode divider registers write once
// - zero divider never starts a cycle
// - protect lock freezes protect bits
// - shadow enabled redirects the two bytes at FC0
//
`timescale 1ns/1ns
`default_nettype none

module epe_ctrl #(
   parameter int PADDR_W = 12,
   parameter int TICKS = epe_pkg::PE_TICKS
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [PADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic normal_mode_flag,
   input wire logic [15:0] shadow_word,
   input wire logic arr_wr,
   input wire logic [11:0] arr_addr,
   input wire logic [15:0] arr_wdata,
   input wire logic arr_word,
   output logic pe_active,
   output logic pe_erase,
   output epe_pkg::epe_size_t pe_size,
   output logic [11:0] pe_addr,
   output logic [15:0] pe_data,
   output logic pe_shadow,
   output logic shadow_disable,
   output logic main_array_open,
   output logic debug_lockout_disable,
   output logic wait_stop
);

   typedef struct packed {
      logic ld_done;
      logic [7:0] cfg;
      logic [9:0] div;
      logic divh_wr;
      logic divl_wr;
      logic lock_wr;
      logic open_wr;
      logic [7:0] prot;
      logic [7:0] prog;
      logic [11:0] addr;
      logic [15:0] data;
      logic word;
      logic running;
      logic cyc_done;
      logic shadow_tgt;
      epe_pkg::epe_size_t size;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } epe_state_t;

   epe_state_t st_r;
   epe_state_t st_nxt;
   logic timer_done;

   // register index from a word-aligned byte address
   function automatic logic [7:0] reg_index(input logic [PADDR_W-1:0] a);
      reg_index = a[9:2];
   endfunction : reg_index

   function automatic logic reg_hit(input logic [PADDR_W-1:0] a);
      logic [7:0] i;
      i = reg_index(a);
      reg_hit = (a[1:0] == 2'h0) &&
                (a[PADDR_W-1:10] == '0) &&
                (i == epe_pkg::IDX_DIV_HIGH || i == epe_pkg::IDX_DIV_LOW ||
                 i == epe_pkg::IDX_MODULE_CFG ||
                 i == epe_pkg::IDX_BLOCK_PROT ||
                 i == epe_pkg::IDX_PROG_CTRL);
   endfunction : reg_hit

   // address lands on the shadow word while it is mapped in
   function automatic logic is_shadow(input logic [11:0] a,
                                      input logic shw_dis);
      is_shadow = !shw_dis && (a[11:1] == epe_pkg::SHADOW_ADDR[11:1]);
   endfunction : is_shadow

   function automatic logic region_blocked(input logic [11:0] a,
                                           input logic [7:0] p);
      logic hit;
      hit = 1'b0;
      if (a >= epe_pkg::REGION0_LO) begin
         hit = p[0];
      end else if (a >= epe_pkg::REGION1_LO) begin
         hit = p[1];
      end else if (a >= epe_pkg::REGION2_LO) begin
         hit = p[2];
      end else if (a >= epe_pkg::REGION3_LO) begin
         hit = p[3];
      end else if (a >= epe_pkg::REGION4_LO) begin
         hit = p[4];
      end
      region_blocked = hit;
   endfunction : region_blocked

   logic pe_on;
   logic latch_on;
   logic locked;
   logic div_zero;
   logic wr_done;
   logic rd_first;
   logic [7:0] widx;
   logic [7:0] wb;
   logic blocked;
   logic bulk_row;
   epe_pkg::epe_size_t sz;

   always_comb begin
      st_nxt = st_r;
      pe_on = st_r.prog[epe_pkg::PC_ENABLE];
      latch_on = st_r.prog[epe_pkg::PC_LATCH];
      locked = st_r.cfg[epe_pkg::CFG_PROT_LOCK];
      div_zero = (st_r.div == 10'h000);
      wr_done = psel && penable && st_r.pready && pwrite && !st_r.pslverr;
      rd_first = psel && penable && !st_r.pready;
      widx = reg_index(paddr);
      wb = pwdata[7:0];
      blocked = 1'b0;
      bulk_row = 1'b0;
      sz = epe_pkg::EPE_SZ_BYTE;

      // shadow word loaded once after reset
      if (!st_r.ld_done) begin
         st_nxt.ld_done = 1'b1;
         st_nxt.cfg[7:4] = shadow_word[15:12];
         st_nxt.div = shadow_word[epe_pkg::SHW_DIV_HIGH_LSB+1:0];
      end

      // apb: one wait state, action at the completing edge
      st_nxt.pready = 1'b0;
      if (rd_first) begin
         st_nxt.pready = 1'b1;
         st_nxt.pslverr = !reg_hit(paddr);
         st_nxt.prdata = '0;
         case (reg_hit(paddr) ? widx : 8'h00)
            epe_pkg::IDX_DIV_HIGH: st_nxt.prdata[1:0] = st_r.div[9:8];
            epe_pkg::IDX_DIV_LOW: st_nxt.prdata[7:0] = st_r.div[7:0];
            epe_pkg::IDX_MODULE_CFG: st_nxt.prdata[7:0] = st_r.cfg;
            epe_pkg::IDX_BLOCK_PROT: st_nxt.prdata[7:0] = st_r.prot;
            epe_pkg::IDX_PROG_CTRL: st_nxt.prdata[7:0] = st_r.prog;
            default: st_nxt.prdata = '0;
         endcase
      end

      if (wr_done) begin
         case (widx)
            // divider write once in normal mode
            epe_pkg::IDX_DIV_HIGH: begin
               if (!latch_on && !(normal_mode_flag && st_r.divh_wr)) begin
                  st_nxt.div[9:8] = wb[1:0];
                  st_nxt.divh_wr = 1'b1;
               end
            end
            epe_pkg::IDX_DIV_LOW: begin
               if (!latch_on && !(normal_mode_flag && st_r.divl_wr)) begin
                  st_nxt.div[7:0] = wb;
                  st_nxt.divl_wr = 1'b1;
               end
            end
            epe_pkg::IDX_MODULE_CFG: begin
               st_nxt.cfg[epe_pkg::CFG_WAIT_STOP] = wb[epe_pkg::CFG_WAIT_STOP];
               st_nxt.cfg[epe_pkg::CFG_DUMMY] = wb[epe_pkg::CFG_DUMMY];
               if (!normal_mode_flag) begin
                  st_nxt.cfg[7:4] = wb[7:4];
                  // lock bit free in special mode
                  st_nxt.cfg[epe_pkg::CFG_PROT_LOCK] =
                     wb[epe_pkg::CFG_PROT_LOCK];
               end else begin
                  // lock bit write once in normal mode
                  if (!st_r.lock_wr) begin
                     st_nxt.cfg[epe_pkg::CFG_PROT_LOCK] =
                        wb[epe_pkg::CFG_PROT_LOCK];
                     st_nxt.lock_wr = 1'b1;
                  end
                  // only closing the main array, and only once
                  if (!st_r.open_wr && !wb[epe_pkg::CFG_MAIN_OPEN]) begin
                     st_nxt.cfg[epe_pkg::CFG_MAIN_OPEN] = 1'b0;
                     st_nxt.open_wr = 1'b1;
                  end
               end
            end
            epe_pkg::IDX_BLOCK_PROT: begin
               if (!pe_on && !locked) begin
                  st_nxt.prot = wb & epe_pkg::PROT_MASK;
               end
            end
            epe_pkg::IDX_PROG_CTRL: begin
               if (!pe_on) begin
                  if (!locked) begin
                     st_nxt.prog[epe_pkg::PC_BULK_PROT] =
                        wb[epe_pkg::PC_BULK_PROT];
                  end
                  st_nxt.prog[epe_pkg::PC_AUTO] = wb[epe_pkg::PC_AUTO];
                  st_nxt.prog[epe_pkg::PC_BYTE] = wb[epe_pkg::PC_BYTE];
                  st_nxt.prog[epe_pkg::PC_ROW] = wb[epe_pkg::PC_ROW];
                  st_nxt.prog[epe_pkg::PC_ERASE] = wb[epe_pkg::PC_ERASE];
                  // latch ignores writes at zero divider
                  if (!div_zero) begin
                     st_nxt.prog[epe_pkg::PC_LATCH] = wb[epe_pkg::PC_LATCH];
                  end
                  st_nxt.prog[epe_pkg::PC_ENABLE] = latch_on &&
                     st_nxt.prog[epe_pkg::PC_LATCH] &&
                     wb[epe_pkg::PC_ENABLE];
               end else begin
                  // only the enable bit may change
                  st_nxt.prog[epe_pkg::PC_ENABLE] = wb[epe_pkg::PC_ENABLE];
               end
            end
            default: st_nxt.prdata = st_r.prdata;
         endcase
      end

      // latches load when armed and idle
      if (arr_wr && latch_on && !pe_on) begin
         st_nxt.addr = arr_word ? {arr_addr[11:1], 1'b0} : arr_addr;
         st_nxt.data = arr_wdata;
         st_nxt.word = arr_word;
      end

      if (!st_r.prog[epe_pkg::PC_ERASE] || st_r.prog[epe_pkg::PC_BYTE]) begin
         sz = st_r.word ? epe_pkg::EPE_SZ_WORD : epe_pkg::EPE_SZ_BYTE;
      end else begin
         bulk_row = 1'b1;
         sz = st_r.prog[epe_pkg::PC_ROW] ? epe_pkg::EPE_SZ_ROW :
                                           epe_pkg::EPE_SZ_BULK;
      end

      // shadow word replaces the two bytes at FC0
      if (is_shadow(st_r.addr, st_r.cfg[epe_pkg::CFG_SHADOW_DIS])) begin
         blocked = st_r.prot[epe_pkg::PROT_SHADOW];
      end else if (!bulk_row) begin
         blocked = region_blocked(st_r.addr, st_r.prot);
      end
      if (bulk_row && st_r.prog[epe_pkg::PC_BULK_PROT]) begin
         blocked = 1'b1;
      end

      if (!pe_on) begin
         st_nxt.running = 1'b0;
         st_nxt.cyc_done = 1'b0;
      end else if (!st_r.running && !st_r.cyc_done && !blocked &&
                   !div_zero) begin
         st_nxt.running = 1'b1;
         st_nxt.size = sz;
         st_nxt.shadow_tgt =
            is_shadow(st_r.addr, st_r.cfg[epe_pkg::CFG_SHADOW_DIS]);
      end else if (st_r.running && timer_done) begin
         // cycle ends after the timed tick count
         st_nxt.running = 1'b0;
         st_nxt.cyc_done = 1'b1;
         if (st_r.prog[epe_pkg::PC_AUTO]) begin
            st_nxt.prog[epe_pkg::PC_ENABLE] = 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '0;
         st_r.cfg <= epe_pkg::CFG_RESET;
         st_r.prot <= epe_pkg::PROT_RESET;
         st_r.prog <= epe_pkg::PC_RESET;
      end else if (clk_en) begin
         st_r <= st_nxt;
      end
   end

   epe_self_timer #(
      .TICKS(TICKS)
   ) u_timer (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .run(st_r.running),
      .divider(st_r.div),
      .done(timer_done)
   );

   assign prdata = st_r.prdata;
   assign pready = st_r.pready;
   assign pslverr = st_r.pslverr;
   assign pe_active = st_r.running;
   assign pe_erase = st_r.prog[epe_pkg::PC_ERASE];
   assign pe_size = st_r.size;
   assign pe_addr = st_r.addr;
   assign pe_data = st_r.data;
   assign pe_shadow = st_r.shadow_tgt;
   assign shadow_disable = st_r.cfg[epe_pkg::CFG_SHADOW_DIS];
   assign main_array_open = st_r.cfg[epe_pkg::CFG_MAIN_OPEN];
   assign debug_lockout_disable = st_r.cfg[epe_pkg::CFG_DBG_LOCKOUT_DIS];
   assign wait_stop = st_r.cfg[epe_pkg::CFG_WAIT_STOP];

endmodule : epe_ctrl

`default_nettype wire

// >>> dv/epe_ctrl_assertions.sv
`timescale 1ns/1ns
`default_nettype none

module epe_ctrl_assertions #(
   parameter int TICKS = epe_pkg::PE_TICKS
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pe_active,
   input wire logic pe_erase,
   input wire epe_pkg::epe_size_t pe_size,
   input wire logic [11:0] pe_addr,
   input wire logic [15:0] pe_data,
   input wire logic pe_shadow,
   input wire logic shadow_disable
);
   // longest run: divider at its ten-bit maximum
   localparam int MAX_RUN = TICKS * 1024;
   logic [31:0] run_cnt_r;
   default clocking dc @(posedge pclk); endclocking
   default disable iff (!presetn);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_cnt_r <= 32'h0;
      end else begin
         run_cnt_r <= pe_active ? run_cnt_r + 32'h1 : 32'h0;
      end
   end
   property p_answer;
      psel && penable && !pready |=> pready;
   endproperty
   a_answer: assert property (p_answer) else $error("no answer");
   property p_frozen;
      pe_active |=> $stable(pe_addr) && $stable(pe_data);
   endproperty
   a_frozen: assert property (p_frozen) else $error("latch moved");
   property p_ctrl;
      pe_active |=> $stable(pe_erase) && $stable(pe_size);
   endproperty
   a_ctrl: assert property (p_ctrl) else $error("control moved");
   property p_prog;
      $rose(pe_active) && !pe_erase |->
         pe_size inside {epe_pkg::EPE_SZ_BYTE, epe_pkg::EPE_SZ_WORD};
   endproperty
   a_prog: assert property (p_prog) else $error("program size");
   property p_word;
      $rose(pe_active) && pe_size == epe_pkg::EPE_SZ_WORD |-> !pe_addr[0];
   endproperty
   a_word: assert property (p_word) else $error("word unaligned");
   property p_shadow;
      $rose(pe_active) && pe_shadow |-> !shadow_disable &&
         pe_addr[11:1] == epe_pkg::SHADOW_ADDR[11:1];
   endproperty
   a_shadow: assert property (p_shadow) else $error("shadow map");
   property p_restart;
      $fell(pe_active) |=> !pe_active;
   endproperty
   a_restart: assert property (p_restart) else $error("restart");
   property p_bound;
      run_cnt_r <= MAX_RUN;
   endproperty
   a_bound: assert property (p_bound) else $error("run too long");
endmodule : epe_ctrl_assertions

bind epe_ctrl epe_ctrl_assertions #(.TICKS(TICKS)) epe_ctrl_assertions_inst (
   .pclk, .presetn, .psel, .penable, .pready, .pe_active, .pe_erase,
   .pe_size, .pe_addr, .pe_data, .pe_shadow, .shadow_disable
);

`default_nettype wire

// >>> dv/epe_array_model.sv
`timescale 1ns/1ns
`default_nettype none

module epe_array_model #(
   // test bit and unmapped bits kept at one, divider 16
   parameter logic [15:0] SHW = 16'hEC10
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pe_active,
   input wire logic pe_erase,
   input wire epe_pkg::epe_size_t pe_size,
   input wire logic [11:0] pe_addr,
   input wire logic [15:0] pe_data,
   input wire logic pe_shadow,
   output logic [15:0] shadow_word,
   output int ops,
   output logic [31:0] last_op
);
   logic act_r;
   // stored high byte EC, ones except the main-open and divider-high bits
   assign shadow_word = SHW;
   // every start recorded, no reads between
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         act_r <= 1'h0;
         ops <= 0;
         last_op <= 32'h0;
      end else begin
         act_r <= pe_active;
         if (pe_active && !act_r) begin
            ops <= ops + 1;
            last_op <= {pe_shadow, pe_erase, pe_size, pe_addr, pe_data};
         end
      end
   end
endmodule : epe_array_model

`default_nettype wire

// >>> dv/eeprom_program_erase_control_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin \
   samples_checked++; \
   if ((g) !== (e)) begin \
      failures++; \
      $display("unexpected at %0t: got %h, expected %h", $time, g, e); \
   end \
end

module eeprom_program_erase_control_tb_top;
   localparam logic [11:0] A_DL = {2'h0, epe_pkg::IDX_DIV_LOW, 2'h0};
   localparam logic [11:0] A_DH = {2'h0, epe_pkg::IDX_DIV_HIGH, 2'h0};
   localparam logic [11:0] A_CF = {2'h0, epe_pkg::IDX_MODULE_CFG, 2'h0};
   localparam logic [11:0] A_BP = {2'h0, epe_pkg::IDX_BLOCK_PROT, 2'h0};
   localparam logic [11:0] A_PC = {2'h0, epe_pkg::IDX_PROG_CTRL, 2'h0};
   logic pclk = 1'h0;
   logic presetn = 1'h0;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0;
   logic normal_mode_flag = 1'h0;
   logic arr_wr = 1'h0;
   logic [11:0] arr_addr = 12'h0;
   logic [15:0] arr_wdata = 16'h0;
   logic arr_word = 1'h0;
   logic [31:0] prdata, rd, last_op;
   logic pready, pslverr, pe_active, pe_erase, pe_shadow, err, ran;
   logic [15:0] shadow_word, pe_data;
   logic shw_dis, arr_open, dbg_dis, wstop;
   logic [11:0] pe_addr;
   epe_pkg::epe_size_t pe_size;
   int ops;
   int failures = 0;
   int samples_checked = 0;
   logic [7:0] sz_b [5] = '{8'h34, 8'h34, 8'h2C, 8'h24, 8'h38};
   logic [11:0] reg_lo [5] = '{12'hFC0, 12'hF80, 12'hF00, 12'hE00, 12'hC00};

   epe_ctrl #(.PADDR_W(12), .TICKS(3)) epe_ctrl_inst (
      .pclk, .presetn, .clk_en(1'h1), .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .normal_mode_flag, .shadow_word,
      .arr_wr, .arr_addr, .arr_wdata, .arr_word, .pe_active, .pe_erase,
      .pe_size, .pe_addr, .pe_data, .pe_shadow, .shadow_disable(shw_dis),
      .main_array_open(arr_open), .debug_lockout_disable(dbg_dis),
      .wait_stop(wstop)
   );
   epe_array_model epe_array_model_inst (
      .pclk, .presetn, .pe_active, .pe_erase, .pe_size, .pe_addr, .pe_data,
      .pe_shadow, .shadow_word, .ops, .last_op
   );

   always #5 pclk = ~pclk;

   task automatic print_verdict();
      if (failures == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : print_verdict

   task automatic xfer(input logic w, input logic [11:0] a,
         input logic [7:0] d);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'h1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
   endtask : xfer

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      xfer(1'h1, a, d);
   endtask : wr

   task automatic chk_rd(input logic [11:0] a, input logic [7:0] e);
      xfer(1'h0, a, 8'h0);
      `CHK(rd, {24'h0, e})
   endtask : chk_rd

   task automatic arr(input logic [11:0] a, input logic [15:0] d,
         input logic w);
      arr_wr <= 1'h1;
      arr_addr <= a;
      arr_wdata <= d;
      arr_word <= w;
      @(posedge pclk);
      arr_wr <= 1'h0;
      @(posedge pclk);
   endtask : arr

   task automatic run_wait();
      int n;
      n = 0;
      ran = 1'h0;
      while (n < 120 && !(ran && pe_active === 1'h0)) begin
         @(posedge pclk);
         n++;
         if (pe_active === 1'h1) ran = 1'h1;
      end
   endtask : run_wait

   task automatic op(input logic [7:0] b, input logic [11:0] a,
         input logic [15:0] d, input logic w);
      wr(A_PC, b | 8'h02);
      arr(a, d, w);
      wr(A_PC, b | 8'h03);
      run_wait();
   endtask : op

   task automatic fin(input logic [7:0] b);
      wr(A_PC, b | 8'h02);
      wr(A_PC, 8'h00);
   endtask : fin

   function automatic logic [1:0] exp_size(input logic [7:0] b, input logic w);
      if (b[2] && !b[4]) begin
         return b[3] ? epe_pkg::EPE_SZ_ROW : epe_pkg::EPE_SZ_BULK;
      end
      return w ? epe_pkg::EPE_SZ_WORD : epe_pkg::EPE_SZ_BYTE;
   endfunction : exp_size

   initial begin
      repeat (20000) @(posedge pclk);
      failures++;
      print_verdict();
   end

   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      chk_rd(A_BP, 8'h9F);
      chk_rd(A_PC, 8'h80);
      chk_rd(A_CF, 8'hEC);
      chk_rd(A_DL, 8'h10);
      chk_rd(A_DH, 8'h00);
      `CHK({dbg_dis, shw_dis, arr_open, wstop}, 4'hD)
      wr(A_DL, 8'h10);
      wr(A_BP + 12'h2, 8'h00);
      `CHK(err, 1'h1)
      chk_rd(A_BP + 12'h2, 8'h00);
      `CHK(err, 1'h1)
      chk_rd(A_BP, 8'h9F);
      wr(A_BP, 8'h00);
      chk_rd(A_BP, 8'h00);
      wr(A_PC, 8'h00);
      for (int i = 0; i < 5; i++) begin
         op(sz_b[i], 12'hC10 + 12'(3 * i), 16'hA5C3, i[0]);
         `CHK(ran, 1'h1)
         `CHK(last_op[30], sz_b[i][2])
         `CHK(last_op[29:28], exp_size(sz_b[i], i[0]))
         `CHK(last_op[27:16], 12'hC10 + 12'(3 * i) & ~{11'h0, i[0]})
         chk_rd(A_PC, sz_b[i] | 8'h02);
         fin(sz_b[i]);
      end
      wr(A_PC, 8'h03);
      chk_rd(A_PC, 8'h02);
      wr(A_PC, 8'h03);
      arr(12'hC30, 16'h0077, 1'h0);
      `CHK(pe_addr, 12'hC1C)
      wr(A_PC, 8'hBF);
      chk_rd(A_PC, 8'h03);
      wr(A_BP, 8'h1F);
      chk_rd(A_BP, 8'h00);
      run_wait();
      chk_rd(A_PC, 8'h03);
      wr(A_PC, 8'h02);
      arr(12'hC40, 16'h1234, 1'h1);
      wr(A_PC, 8'h03);
      run_wait();
      `CHK(ops, 7)
      `CHK(last_op[27:0], {12'hC40, 16'h1234})
      fin(8'h00);
      for (int k = 0; k < 5; k++) begin
         wr(A_BP, 8'h01 << k);
         op(8'h20, reg_lo[k], 16'h0055, 1'h0);
         `CHK(ran, 1'h0)
         chk_rd(A_PC, 8'h23);
         fin(8'h20);
      end
      wr(A_BP, 8'h00);
      op(8'hAC, 12'hC00, 16'h0000, 1'h0);
      `CHK(ran, 1'h0)
      fin(8'h00);
      wr(A_CF, 8'hEE);
      wr(A_BP, 8'h1F);
      chk_rd(A_BP, 8'h00);
      wr(A_CF, 8'hAC);
      `CHK({dbg_dis, shw_dis, arr_open, wstop}, 4'h9)
      wr(A_BP, 8'h80);
      op(8'h20, epe_pkg::SHADOW_ADDR, 16'hFC10, 1'h1);
      `CHK(ran, 1'h0)
      fin(8'h20);
      wr(A_BP, 8'h00);
      op(8'h20, epe_pkg::SHADOW_ADDR, 16'hFC10, 1'h1);
      `CHK(ran, 1'h1)
      `CHK(last_op[31], 1'h1)
      fin(8'h20);
      wr(A_BP, 8'h80);
      wr(A_DL, 8'h00);
      wr(A_PC, 8'h02);
      chk_rd(A_PC, 8'h00);
      normal_mode_flag <= 1'h1;
      presetn <= 1'h0;
      repeat (3) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      wr(A_DL, 8'h20);
      chk_rd(A_DL, 8'h20);
      wr(A_DL, 8'h30);
      chk_rd(A_DL, 8'h20);
      print_verdict();
   end
endmodule : eeprom_program_erase_control_tb_top

`default_nettype wire
